// ---- pkg/irq_hazard_consts.svh ----
// constants for the interrupt request hazard block
`ifndef IRQ_HAZARD_CONSTS_SVH
`define IRQ_HAZARD_CONSTS_SVH

// edge sensitivity codes per external line
`define EDGE_SEL_FALL 2'h0
`define EDGE_SEL_RISE 2'h1
`define EDGE_SEL_BOTH 2'h2
`define EDGE_SEL_NONE 2'h3

// vector addresses: reset at the top, source n sits (n+1) steps below it
`define VEC_RESET_ADDR 16'hfffe
`define VEC_STEP 16'h0002

// priority level width and flags word width
`define LEVEL_W 2
`define CCW_W 8

`endif

// ---- pkg/irq_hazard_pkg.sv ----
// types shared by the interrupt request hazard block
`include "irq_hazard_consts.svh"

package irq_hazard_pkg;

    typedef enum logic [1:0] {
        EDGE_FALL = `EDGE_SEL_FALL,
        EDGE_RISE = `EDGE_SEL_RISE,
        EDGE_BOTH = `EDGE_SEL_BOTH,
        EDGE_NONE = `EDGE_SEL_NONE
    } edge_sel_t;

    // what the cpu core tells the controller each cycle
    typedef struct packed {
        logic flags_restore_exec;
        logic in_handler;
        logic nested;
        logic global_mask;
        logic [`LEVEL_W-1:0] cur_level;
        logic vector_ack;
    } cpu_status_t;

    // write port onto the condition_code_word
    typedef struct packed {
        logic wr;
        logic [`CCW_W-1:0] data;
    } ccw_wr_t;

endpackage : irq_hazard_pkg

// ---- verilog/ext_edge_detect.sv ----
// external interrupt pin synchroniser and blankable edge detector
`timescale 1ns/1ps

module ext_edge_detect
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_pin,
    input wire irq_hazard_pkg::edge_sel_t i_edge_sel,
    input wire logic i_blank,
    output logic o_edge,
    output logic o_level
);
    import irq_hazard_pkg::*;

    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic rise;
    logic fall;
    logic raw;

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= i_pin;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    assign rise = sync2_ff & ~prev_ff;
    assign fall = ~sync2_ff & prev_ff;

    always_comb
    begin
        unique case (i_edge_sel)
            EDGE_FALL: raw = fall;
            EDGE_RISE: raw = rise;
            EDGE_BOTH: raw = rise | fall;
            EDGE_NONE: raw = 1'b0;
        endcase
    end

    // blanked for the access cycle so a config change cannot fake an edge
    assign o_edge = raw & ~i_blank;
    assign o_level = sync2_ff;

    AST_BLANK_KILLS_EDGE: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        i_blank |-> !o_edge)
        else $error("edge reported inside blanking cycle");

endmodule : ext_edge_detect

// ---- verilog/interrupt_request_hazards.sv ----
// interrupt request logic with blanked edge detectors and flag hazards
`timescale 1ns/1ps
`include "irq_hazard_consts.svh"

module interrupt_request_hazards
#(
    parameter int NEXT = 4,
    parameter int NINT = 4
)
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [NEXT-1:0] i_ext_pin,
    input wire irq_hazard_pkg::edge_sel_t i_edge_sel [NEXT],
    input wire logic [NEXT-1:0] i_cfg_access,
    input wire logic [NINT-1:0] i_int_event,
    input wire logic [NEXT+NINT-1:0] i_src_enable,
    input wire logic [NEXT+NINT-1:0] i_clear,
    input wire logic [(NEXT+NINT)*`LEVEL_W-1:0] i_src_level,
    input wire irq_hazard_pkg::cpu_status_t i_cpu,
    input wire logic [`CCW_W-1:0] i_ccw,
    output logic o_irq,
    output logic [15:0] o_vector,
    output irq_hazard_pkg::ccw_wr_t o_ccw,
    output logic [NEXT-1:0] o_pin_level,
    output logic [NEXT+NINT-1:0] o_pending
);
    import irq_hazard_pkg::*;

    localparam int NSRC = NEXT + NINT;
    localparam int IW = (NSRC > 1) ? $clog2(NSRC) : 1;

    logic [NEXT-1:0] ext_edge;
    logic [NSRC-1:0] set_vec;
    logic [NSRC-1:0] clr_vec;
    logic [NSRC-1:0] pend_ff;
    logic [NSRC-1:0] live;
    logic [NSRC-1:0] unsafe;
    logic [NSRC-1:0] rise_vec;
    logic [IW-1:0] grant_ff;
    logic grant_ok_ff;
    logic bad_ff;
    logic new_req;
    logic hazard;
    logic restore_hit;
    logic [IW:0] first;
    logic [15:0] vector_ff;
    ccw_wr_t ccw_ff;

    // lowest index wins among live requests
    function automatic logic [IW:0] pick_first(input logic [NSRC-1:0] req);
        logic [IW:0] res;
        res = '0;
        for (int k = NSRC - 1; k >= 0; k--)
        begin
            if (req[k])
            begin
                res = {1'b1, IW'(k)};
            end
        end
        return res;
    endfunction : pick_first

    function automatic logic [15:0] vec_of(input logic [IW-1:0] idx);
        return `VEC_RESET_ADDR - (16'(idx) + 16'h0001) * `VEC_STEP;
    endfunction : vec_of

    for (genvar g = 0; g < NEXT; g++)
    begin : g_ext
        ext_edge_detect u_det
        (
            .i_clock(i_clock),
            .i_reset_n(i_reset_n),
            .i_pin(i_ext_pin[g]),
            .i_edge_sel(i_edge_sel[g]),
            .i_blank(i_cfg_access[g]),
            .o_edge(ext_edge[g]),
            .o_level(o_pin_level[g])
        );
    end

    assign set_vec = {i_int_event, ext_edge};
    assign rise_vec = set_vec & ~pend_ff;
    assign new_req = |rise_vec;
    assign live = pend_ff & i_src_enable;
    assign first = pick_first(live);
    // a masked core cannot take the request, so the restore keeps the source id
    assign restore_hit = i_cpu.flags_restore_exec && new_req && !i_cpu.global_mask;

    // a vector ack clears only the source it was granted for
    always_comb
    begin
        clr_vec = i_clear;
        if (i_cpu.vector_ack && grant_ok_ff && !bad_ff)
        begin
            clr_vec[grant_ff] = 1'b1;
        end
    end

    // set wins over clear so a coincident edge is never lost
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pend_ff <= '0;
        end
        else
        begin
            pend_ff <= (pend_ff & ~clr_vec) | set_vec;
        end
    end

    // recognition while flags are being restored loses the source id
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            bad_ff <= 1'b0;
        end
        else if (restore_hit)
        begin
            bad_ff <= 1'b1;
        end
        else if (i_cpu.vector_ack)
        begin
            bad_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            grant_ff <= '0;
            grant_ok_ff <= 1'b0;
            vector_ff <= `VEC_RESET_ADDR;
        end
        else
        begin
            {grant_ok_ff, grant_ff} <= first;
            if (restore_hit || (bad_ff && !i_cpu.vector_ack))
            begin
                vector_ff <= `VEC_RESET_ADDR;
            end
            else
            begin
                vector_ff <= vec_of(first[IW-1:0]);
            end
        end
    end

    // a clear is harmless in a handler (nested: only at >= level), on a disabled source,
    // or under the global mask, which is what the bracketing sequence in software relies on
    always_comb
    begin
        for (int k = 0; k < NSRC; k++)
        begin
            unsafe[k] = i_src_enable[k] && !i_cpu.global_mask
                && !(i_cpu.in_handler && (!i_cpu.nested
                || i_cpu.cur_level >= i_src_level[k*`LEVEL_W +: `LEVEL_W]));
        end
    end

    assign hazard = |(rise_vec & i_clear & unsafe);

    // the corruption is modelled as a deterministic inversion so tests can see it
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ccw_ff <= '0;
        end
        else
        begin
            ccw_ff.wr <= hazard;
            ccw_ff.data <= hazard ? ~i_ccw : ccw_ff.data;
        end
    end

    // software must mask before restoring flags; the controller does not guard it
    assign o_irq = (|live) && !i_cpu.global_mask;
    assign o_vector = vector_ff;
    assign o_ccw = ccw_ff;
    assign o_pending = pend_ff;

    sequence s_restore_hit;
        restore_hit;
    endsequence

    sequence s_reset_vec_held;
        (o_vector == `VEC_RESET_ADDR) [*1];
    endsequence

    AST_RESTORE_GIVES_RESET: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        s_restore_hit |=> s_reset_vec_held ##0 bad_ff)
        else $error("reset vector not presented after restore-time request");

    AST_BAD_HOLDS_UNTIL_ACK: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (bad_ff && !i_cpu.vector_ack) |=> (o_vector == `VEC_RESET_ADDR))
        else $error("reset vector dropped before ack");

    AST_MASKED_RESTORE_OK: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_cpu.flags_restore_exec && new_req && i_cpu.global_mask && !bad_ff)
        |=> !bad_ff)
        else $error("masked restore-time request lost its source");

    AST_BLANKED_NO_PEND: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_cfg_access[0] && !pend_ff[0]) |=> !pend_ff[0])
        else $error("blanked edge became pending");

    AST_BLANK_ONE_CYCLE: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (|(i_cfg_access & ext_edge)) == 1'b0)
        else $error("edge passed during config access");

    AST_EDGE_LATCHED: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        ext_edge[0] |=> pend_ff[0] ##1 (pend_ff[0] || $past(clr_vec[0])))
        else $error("detected edge not latched");

    AST_PEND_HELD: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (pend_ff[NSRC-1] && !clr_vec[NSRC-1]) |=> pend_ff[NSRC-1])
        else $error("pending dropped without clear");

    AST_HAZARD_CORRUPTS: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        hazard |=> (o_ccw.wr && o_ccw.data == ~$past(i_ccw)))
        else $error("hazard did not corrupt flags word");

    AST_DISABLED_SAFE: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        ((i_clear & i_src_enable) == '0) |=> !o_ccw.wr)
        else $error("flags corrupted on clear of disabled source");

    AST_NONNESTED_SAFE: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_cpu.in_handler && !i_cpu.nested) |=> !o_ccw.wr)
        else $error("flags corrupted inside non-nested handler");

    AST_NESTED_TOP_SAFE: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_cpu.in_handler && i_cpu.nested && i_cpu.cur_level == 2'h3) |=> !o_ccw.wr)
        else $error("flags corrupted in top-level nested handler");

endmodule : interrupt_request_hazards

// ---- test/cpu_core_model.sv ----
// cpu core stand-in: acknowledges vectors and runs flag restores
`timescale 1ns/1ps

module cpu_core_model
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_irq,
    input wire logic [15:0] i_vector,
    input wire logic i_restore,
    input wire logic i_obey,
    input wire logic i_slow,
    input wire irq_hazard_pkg::cpu_status_t i_ctx,
    output irq_hazard_pkg::cpu_status_t o_cpu,
    output logic [15:0] o_vec,
    output int o_acks
);
    import irq_hazard_pkg::*;
    logic mask_ff;
    logic exec_ff;
    logic ack_ff;
    logic [3:0] wait_ff;
    always_comb
    begin
        o_cpu = i_ctx;
        o_cpu.global_mask = i_ctx.global_mask | mask_ff;
        o_cpu.flags_restore_exec = exec_ff;
        o_cpu.vector_ack = ack_ff;
    end
    // an obedient core sets the mask one cycle ahead and keeps it through the restore
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mask_ff <= 1'b0;
            exec_ff <= 1'b0;
        end
        else
        begin
            mask_ff <= i_restore ? i_obey : (mask_ff & !exec_ff);
            exec_ff <= i_restore ? !i_obey : (mask_ff & !exec_ff);
        end
    end
    // the vector is taken at the edge that closes the acknowledge cycle
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ack_ff <= 1'b0;
            wait_ff <= 4'h0;
            o_vec <= 16'h0000;
            o_acks <= 0;
        end
        else
        begin
            ack_ff <= 1'b0;
            if (ack_ff)
            begin
                o_vec <= i_vector;
                o_acks <= o_acks + 1;
                wait_ff <= 4'h0;
            end
            else if (i_irq && !o_cpu.global_mask)
            begin
                if (wait_ff >= (i_slow ? 4'h6 : 4'h1))
                    ack_ff <= 1'b1;
                else
                    wait_ff <= wait_ff + 4'h1;
            end
        end
    end
endmodule : cpu_core_model

// ---- test/interrupt_request_hazards_bench.sv ----
// self-checking bench for the interrupt request hazard block
`timescale 1ns/1ps

module interrupt_request_hazards_bench;
    import irq_hazard_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] pin = 4'h0;
    edge_sel_t sel [4];
    logic [3:0] cfg = 4'h0;
    logic [3:0] ev = 4'h0;
    logic [7:0] en = 8'h00;
    logic [7:0] clr = 8'h00;
    logic [15:0] lvl = 16'h0000;
    logic [7:0] ccw = 8'h00;
    cpu_status_t ctx = '0;
    logic restore = 1'b0;
    logic obey = 1'b0;
    logic slow = 1'b0;
    logic irq;
    logic [15:0] vector;
    ccw_wr_t ccw_o;
    logic [3:0] pin_level;
    logic [7:0] pending;
    cpu_status_t cpu;
    logic [15:0] vec;
    int acks;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    logic [31:0] seed = 32'hd133;
    logic [7:0] cases [6] = '{8'h03, 8'h8e, 8'hea, 8'hdb, 8'hf6, 8'h00};

    always #2.5 clock = ~clock;

    interrupt_request_hazards #(.NEXT(4), .NINT(4)) u_dut (.i_clock(clock), .i_reset_n(reset_n),
        .i_ext_pin(pin), .i_edge_sel(sel), .i_cfg_access(cfg), .i_int_event(ev),
        .i_src_enable(en), .i_clear(clr), .i_src_level(lvl), .i_cpu(cpu), .i_ccw(ccw),
        .o_irq(irq), .o_vector(vector), .o_ccw(ccw_o), .o_pin_level(pin_level),
        .o_pending(pending));

    cpu_core_model u_cpu (.i_clock(clock), .i_reset_n(reset_n), .i_irq(irq), .i_vector(vector),
        .i_restore(restore), .i_obey(obey), .i_slow(slow), .i_ctx(ctx), .o_cpu(cpu),
        .o_vec(vec), .o_acks(acks));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic clear(input int k);
        clr <= 8'(1) << k;
        tick(1);
        clr <= 8'h00;
        tick(2);
    endtask : clear

    task automatic wait_ack();
        int n;
        n = acks;
        for (int i = 0; i < 60 && acks == n; i++)
            tick(1);
        #1;
    endtask : wait_ack

    // the request always lands in the restore cycle itself; an obedient core masks first
    task automatic run_restore(input logic ob);
        obey <= ob;
        restore <= 1'b1;
        tick(1);
        restore <= 1'b0;
        if (ob)
            tick(1);
        ev <= 4'h1;
        tick(1);
        ev <= 4'h0;
    endtask : run_restore

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            results();
        end
    end

    initial
    begin
        logic pl;
        int k;
        logic [7:0] c;
        for (int s = 0; s < 4; s++)
            sel[s] = EDGE_NONE;
        tick(12);
        reset_n <= 1'b1;
        tick(4);
        for (int s = 0; s < 4; s++)
        begin
            sel[s] <= edge_sel_t'(s[1:0]);
            pin[s] <= 1'b1;
            tick(5);
            chk("pend_rise", 16'(s == 1 || s == 2), 16'(pending[s]));
            chk("pin_level", 16'h0001, 16'(pin_level[s]));
            clear(s);
            pin[s] <= 1'b0;
            tick(5);
            chk("pend_fall", 16'(s == 0 || s == 2), 16'(pending[s]));
            clear(s);
        end
        sel[0] <= EDGE_BOTH;
        for (int d = 1; d < 4; d++)
        begin
            pl = pin_level[0];
            pin[0] <= ~pin[0];
            tick(d);
            cfg <= 4'h1;
            tick(1);
            cfg <= 4'h0;
            tick(5);
            chk("blank", 16'(d != 2), 16'(pending[0]));
            chk("pin_after", 16'(!pl), 16'(pin_level[0]));
            // software view: level moved but nothing pending means the edge was lost
            chk("missed", 16'(d == 2), 16'(pl != pin_level[0] && !pending[0]));
            clear(0);
        end
        for (int i = 0; i < 12; i++)
        begin
            seed = lfsr(seed);
            c = cases[i % 6];
            k = 4 + seed[1:0];
            ctx <= {1'b0, c[7], c[6], 1'b0, c[5:4], 1'b0};
            lvl <= 16'(c[3:2]) << (2 * k);
            en <= 8'(c[1]) << k;
            tick(1);
            ev <= 4'(1) << (k - 4);
            clr <= 8'(1) << k;
            ccw <= seed[15:8];
            tick(1);
            ev <= 4'h0;
            clr <= 8'h00;
            #1;
            chk("ccw_wr", 16'(c[0]), 16'(ccw_o.wr));
            if (c[0])
                chk("ccw_data", {8'h00, ~seed[15:8]}, 16'(ccw_o.data));
            tick(1);
            #1;
            chk("ccw_pulse", 16'h0000, 16'(ccw_o.wr));
            clear(k);
        end
        // software clears an active request with the global mask set (bit 3 of the status)
        ctx <= 7'h08;
        en <= 8'h10;
        tick(1);
        ev <= 4'h1;
        clr <= 8'h10;
        tick(1);
        ev <= 4'h0;
        clr <= 8'h00;
        #1;
        chk("masked_clear", 16'h0000, 16'(ccw_o.wr));
        chk("masked_irq", 16'h0000, 16'(irq));
        clear(4);
        ctx <= '0;
        en <= 8'h10;
        run_restore(1'b0);
        wait_ack();
        chk("reset_vec", 16'hfffe, vec);
        chk("still_pend", 16'h0001, 16'(pending[4]));
        wait_ack();
        chk("src_vec", 16'hfff4, vec);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            slow <= seed[0];
            tick(3);
            run_restore(1'b1);
            #1;
            chk("irq_live", 16'h0001, 16'(irq));
            wait_ack();
            chk("masked_vec", 16'hfff4, vec);
            tick(2);
            chk("acked", 16'h0000, 16'(pending[4]));
        end
        results();
    end
endmodule : interrupt_request_hazards_bench
